// ### fes_params.svh
// Constants for the parallel flash command controller
`ifndef FES_PARAMS_SVH
`define FES_PARAMS_SVH
`define FES_UNLOCK_ADDR1 19'h05555
`define FES_UNLOCK_ADDR2 19'h02aaa
`define FES_UNLOCK_DATA1 8'haa
`define FES_UNLOCK_DATA2 8'h55
`define FES_CMD_ERASE_SETUP 8'h80
`define FES_CMD_CHIP_ERASE 8'h10
`define FES_CMD_PROGRAM 8'ha0
`define FES_CMD_AUTOSELECT 8'h90
`define FES_CMD_RESET 8'hf0
`define FES_ID_MAKER_ADDR 19'h00000
`define FES_ID_VARIANT_ADDR 19'h00001
`define FES_ID_PROTECT_ADDR 19'h3c002
`define FES_POLL_BIT 7
`define FES_TOGGLE_BIT 6
`define FES_CLK_MHZ 125
`define FES_STROBE_NS 80
`define FES_STROBE_CYC ((`FES_STROBE_NS * `FES_CLK_MHZ + 999) / 1000)
`define FES_HV_SETTLE_US 10
`define FES_HV_SETTLE_CYC (`FES_HV_SETTLE_US * `FES_CLK_MHZ)
`define FES_PROG_MAX_US 35
`define FES_PROG_MAX_CYC (`FES_PROG_MAX_US * `FES_CLK_MHZ)
`define FES_ERASE_MAX_MS 3000
`define FES_ERASE_MAX_CYC (`FES_ERASE_MAX_MS * 1000 * `FES_CLK_MHZ)
`endif

// ### fes_pkg.sv
// Types for the parallel flash command controller
package fes_pkg;
   typedef enum logic [2:0] {fes_op_read, fes_op_program, fes_op_chip_erase, fes_op_id_cmd,
      fes_op_id_hv, fes_op_lock, fes_op_unlock, fes_op_reset} fes_op_type;
   typedef struct packed {
      fes_op_type op;
      logic [18:0] addr;
      logic [7:0] data;
   } fes_req_type;
   typedef struct packed {
      logic [7:0] data;
      logic ok;
      logic timeout;
   } fes_rsp_type;
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic ce_hv;
      logic oe_hv;
      logic id_voltage_address_pin_hv;
      logic [18:0] addr;
   } fes_pins_type;
endpackage

// ### fes_flash_host.sv
// Host controller driving the parallel flash pins
`timescale 1ns/10ps
`default_nettype none
`include "fes_params.svh"
// Overview of operation
// R1 - Chip erase is six writes: unlock pair, 80h setup, unlock pair, 10h.
// R2 - Device starts erasing at the last write strobe rising edge.
// R3 - Erase is done when a read returns one on the poll bit.
// R4 - While busy, the poll bit reads inverted from the loaded value.
// R5 - After completion the poll bit is true and new operations accepted.
// R6 - While busy, the alternating status bit flips on each read.
// R7 - Host may toggle-poll anytime; two equal reads mean done.
// R8 - Lock: high voltage on output enable and address pin nine, select and write low.
// R9 - Unlock: high voltage on output enable, select, address pin nine; write low.
// R10 - Identification entered by high voltage on address pin nine or command.
// R11 - Identification left when voltage removed or another command written.
// R12 - Identification read at protection location gives 01h locked, 00h unlocked.
// R13 - Identification read at address ending one gives the boot variant code.
// R14 - Identification read at address ending zero gives the maker code.
// R15 - Device ignores select or write pulses below the glitch threshold.
// R16 - No programming while output enable low or select or write high.
// R17 - Host waits for poll success or a maximum-time timeout.
// R18 - Byte program is four writes: unlock pair, A0h, target address and data.
// R19 - Device discards program writes during an erase.
// R20 - A broken command sequence returns the device to array read.
module fes_flash_host #(
   parameter int unsigned PROG_MAX_CYC = `FES_PROG_MAX_CYC,
   parameter int unsigned ERASE_MAX_CYC = `FES_ERASE_MAX_CYC,
   parameter int unsigned HV_SETTLE_CYC = `FES_HV_SETTLE_CYC
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_req_valid,
   input wire fes_pkg::fes_req_type i_req,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output fes_pkg::fes_rsp_type o_rsp,
   output fes_pkg::fes_pins_type o_pins,
   output logic [7:0] o_dq,
   output logic o_dq_oe,
   input wire logic [7:0] i_dq
);
   import fes_pkg::*;
   typedef enum {st_idle, st_setup, st_strobe, st_gap, st_rd_strobe, st_check, st_hv_hold,
      st_done} fes_state_type;
   localparam int unsigned STROBE_CYC = `FES_STROBE_CYC;
   localparam int CW = 32;
   fes_state_type state_reg, state_next;
   fes_req_type req_reg, req_next;
   fes_pins_type pins_reg, pins_next;
   fes_rsp_type rsp_reg, rsp_next;
   logic [7:0] dq_reg, dq_next, last_rd_reg, last_rd_next, dq_s1_reg, dq_s2_reg;
   logic [2:0] step_reg, step_next, nsteps_reg, nsteps_next;
   logic [CW-1:0] cnt_reg, cnt_next, wait_reg, wait_next;
   logic dq_oe_reg, dq_oe_next, have_last_reg, have_last_next, polling_reg, polling_next;
   logic rsp_valid_reg, rsp_valid_next;
   // Address and data of each write step of a command sequence
   function automatic logic [26:0] seq_word(input fes_req_type r, input logic [2:0] s);
      logic [7:0] cmd;
      cmd = (r.op == fes_op_program) ? `FES_CMD_PROGRAM
         : (r.op == fes_op_chip_erase) ? `FES_CMD_ERASE_SETUP : `FES_CMD_AUTOSELECT;
      if (r.op == fes_op_reset)
         return {`FES_UNLOCK_ADDR1, `FES_CMD_RESET};
      case (s)
         3'h1, 3'h4: return {`FES_UNLOCK_ADDR2, `FES_UNLOCK_DATA2};
         3'h2: return {`FES_UNLOCK_ADDR1, cmd};
         3'h3: return (r.op == fes_op_program) ? {r.addr, r.data}
            : {`FES_UNLOCK_ADDR1, `FES_UNLOCK_DATA1};
         3'h5: return {`FES_UNLOCK_ADDR1, `FES_CMD_CHIP_ERASE};
         default: return {`FES_UNLOCK_ADDR1, `FES_UNLOCK_DATA1};
      endcase
   endfunction
   always_comb
   begin
      state_next = state_reg;
      req_next = req_reg;
      pins_next = pins_reg;
      dq_next = dq_reg;
      dq_oe_next = dq_oe_reg;
      step_next = step_reg;
      nsteps_next = nsteps_reg;
      cnt_next = cnt_reg;
      wait_next = wait_reg;
      last_rd_next = last_rd_reg;
      have_last_next = have_last_reg;
      polling_next = polling_reg;
      rsp_next = rsp_reg;
      rsp_valid_next = 1'b0;
      if (state_reg != st_idle && state_reg != st_done && polling_reg)
         wait_next = wait_reg + 1;
      case (state_reg)
         st_idle:
         begin
            if (i_req_valid)
            begin
               req_next = i_req;
               step_next = 3'h0;
               polling_next = 1'b0;
               wait_next = '0;
               have_last_next = 1'b0;
               cnt_next = '0;
               pins_next.addr = i_req.addr;
               case (i_req.op)
                  // R18 four-write program
                  fes_op_program: nsteps_next = 3'h4;
                  // R1 six-write erase
                  fes_op_chip_erase: nsteps_next = 3'h6;
                  // R10 identify by command
                  fes_op_id_cmd: nsteps_next = 3'h3;
                  // R20 reset to array read
                  fes_op_reset: nsteps_next = 3'h1;
                  default: nsteps_next = 3'h0;
               endcase
               if (i_req.op == fes_op_read)
                  state_next = st_rd_strobe;
               else if (i_req.op inside {fes_op_id_hv, fes_op_lock, fes_op_unlock})
               begin
                  // R10 raise address pin nine
                  pins_next.id_voltage_address_pin_hv = 1'b1;
                  if (i_req.op != fes_op_id_hv)
                  begin
                     // R8 R9 high voltage, write low
                     pins_next.oe_hv = 1'b1;
                     pins_next.we_n = 1'b0;
                     pins_next.ce_hv = (i_req.op == fes_op_unlock);
                     pins_next.ce_n = (i_req.op == fes_op_unlock);
                  end
                  state_next = st_hv_hold;
               end
               else
                  state_next = st_setup;
            end
         end
         st_setup:
         begin
            // R16 read strobe off during writes
            pins_next.oe_n = 1'b1;
            pins_next.ce_n = 1'b0;
            {pins_next.addr, dq_next} = seq_word(req_reg, step_reg);
            dq_oe_next = 1'b1;
            pins_next.we_n = 1'b0;
            cnt_next = '0;
            state_next = st_strobe;
         end
         st_strobe:
         begin
            // R15 strobe well above glitch width
            cnt_next = cnt_reg + 1;
            if (cnt_reg + 1 >= CW'(STROBE_CYC))
            begin
               // R2 rising edge launches the operation
               pins_next.we_n = 1'b1;
               cnt_next = '0;
               state_next = st_gap;
            end
         end
         st_gap:
         begin
            cnt_next = cnt_reg + 1;
            if (cnt_reg + 1 >= CW'(STROBE_CYC))
            begin
               dq_oe_next = 1'b0;
               pins_next.ce_n = 1'b1;
               cnt_next = '0;
               if (step_reg + 3'h1 < nsteps_reg)
               begin
                  step_next = step_reg + 3'h1;
                  state_next = st_setup;
               end
               else if (req_reg.op == fes_op_program || req_reg.op == fes_op_chip_erase)
               begin
                  polling_next = 1'b1;
                  pins_next.addr = req_reg.addr;
                  state_next = st_rd_strobe;
               end
               else
               begin
                  rsp_next = '{data: 8'h00, ok: 1'b1, timeout: 1'b0};
                  state_next = st_done;
               end
            end
         end
         st_rd_strobe:
         begin
            pins_next.ce_n = 1'b0;
            pins_next.oe_n = 1'b0;
            cnt_next = cnt_reg + 1;
            if (cnt_reg + 1 >= CW'(STROBE_CYC) + 3)
            begin
               pins_next.oe_n = 1'b1;
               pins_next.ce_n = 1'b1;
               cnt_next = '0;
               state_next = st_check;
            end
         end
         st_check:
         begin
            last_rd_next = dq_s2_reg;
            have_last_next = 1'b1;
            // R12 R13 R14 plain read done
            // R7 toggle bit stable
            // R3 R4 R5 poll bit one for erase, equal to data bit 7 for program
            if (!polling_reg || (have_last_reg
               && last_rd_reg[`FES_TOGGLE_BIT] == dq_s2_reg[`FES_TOGGLE_BIT]
               && dq_s2_reg[`FES_POLL_BIT] == ((req_reg.op == fes_op_chip_erase) ? 1'b1
               : req_reg.data[`FES_POLL_BIT])))
            begin
               rsp_next = '{data: dq_s2_reg, ok: 1'b1, timeout: 1'b0};
               state_next = st_done;
            end
            // R17 give up at the maximum time
            else if (wait_reg >= ((req_reg.op == fes_op_chip_erase) ? CW'(ERASE_MAX_CYC)
               : CW'(PROG_MAX_CYC)))
            begin
               rsp_next = '{data: dq_s2_reg, ok: 1'b0, timeout: 1'b1};
               state_next = st_done;
            end
            else
               state_next = st_rd_strobe;
         end
         st_hv_hold:
         begin
            cnt_next = cnt_reg + 1;
            if (cnt_reg + 1 >= CW'(HV_SETTLE_CYC))
            begin
               cnt_next = '0;
               if (req_reg.op == fes_op_id_hv)
                  state_next = st_rd_strobe;
               else
               begin
                  // R11 drop voltage, leave special mode
                  pins_next = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, ce_hv: 1'b0,
                     oe_hv: 1'b0, id_voltage_address_pin_hv: 1'b0, addr: req_reg.addr};
                  rsp_next = '{data: 8'h00, ok: 1'b1, timeout: 1'b0};
                  state_next = st_done;
               end
            end
         end
         st_done:
         begin
            pins_next.id_voltage_address_pin_hv = 1'b0;
            rsp_valid_next = 1'b1;
            state_next = st_idle;
         end
         default: state_next = st_idle;
      endcase
   end
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_reg <= st_idle;
         req_reg <= '0;
         pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, ce_hv: 1'b0, oe_hv: 1'b0,
            id_voltage_address_pin_hv: 1'b0, addr: 19'h00000};
         dq_reg <= 8'h00;
         dq_oe_reg <= 1'b0;
         step_reg <= 3'h0;
         nsteps_reg <= 3'h0;
         cnt_reg <= '0;
         wait_reg <= '0;
         last_rd_reg <= 8'h00;
         have_last_reg <= 1'b0;
         polling_reg <= 1'b0;
         rsp_reg <= '0;
         rsp_valid_reg <= 1'b0;
         dq_s1_reg <= 8'h00;
         dq_s2_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         req_reg <= req_next;
         pins_reg <= pins_next;
         dq_reg <= dq_next;
         dq_oe_reg <= dq_oe_next;
         step_reg <= step_next;
         nsteps_reg <= nsteps_next;
         cnt_reg <= cnt_next;
         wait_reg <= wait_next;
         last_rd_reg <= last_rd_next;
         have_last_reg <= have_last_next;
         polling_reg <= polling_next;
         rsp_reg <= rsp_next;
         rsp_valid_reg <= rsp_valid_next;
         // Data pins pass two flops
         dq_s1_reg <= i_dq;
         dq_s2_reg <= dq_s1_reg;
      end
   end
   assign o_req_ready = (state_reg == st_idle);
   assign o_rsp_valid = rsp_valid_reg;
   assign o_rsp = rsp_reg;
   assign o_pins = pins_reg;
   assign o_dq = dq_reg;
   assign o_dq_oe = dq_oe_reg;
endmodule
`default_nettype wire

// ### fes_flash_host_properties.sv
// Port checker for the flash command controller
`timescale 1ns/10ps
`default_nettype none
module fes_host_chk (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_req_valid,
   input wire fes_pkg::fes_req_type i_req,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   input wire fes_pkg::fes_rsp_type o_rsp,
   input wire fes_pkg::fes_pins_type o_pins,
   input wire logic [7:0] o_dq,
   input wire logic o_dq_oe,
   input wire logic [7:0] i_dq
);
   import fes_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   AST_TAKE_BUSY: assert property (i_req_valid && o_req_ready |=> !o_req_ready)
      else $error("request taken while busy");
   AST_RSP_PULSE: assert property (o_rsp_valid |=> !o_rsp_valid)
      else $error("response pulse too long");
   AST_READ_NO_WRITE: assert property (!o_pins.oe_n |-> o_pins.we_n && !o_dq_oe)
      else $error("write or drive during read");
   AST_WE_WIDTH: assert property ($fell(o_pins.we_n) |-> !o_pins.we_n [*3])
      else $error("write strobe too narrow");
   AST_WRITE_QUAL: assert property (!o_pins.we_n && !o_pins.oe_hv |-> !o_pins.ce_n && o_dq_oe)
      else $error("write strobe without select or data");
   AST_WRITE_STABLE: assert property (!o_pins.we_n && !$past(o_pins.we_n)
      |-> $stable({o_dq, o_pins.addr})) else $error("write data moved under strobe");
   AST_UNLOCK_PINS: assert property (o_pins.ce_hv |-> o_pins.oe_hv && !o_pins.we_n
      && o_pins.id_voltage_address_pin_hv) else $error("bad unlock pins");
   AST_LOCK_PINS: assert property (o_pins.oe_hv && !o_pins.ce_hv |-> !o_pins.ce_n
      && !o_pins.we_n && o_pins.id_voltage_address_pin_hv) else $error("bad lock pins");
   AST_READ_WIDTH: assert property ($fell(o_pins.oe_n) |-> !o_pins.oe_n [*8])
      else $error("read strobe too short");
   AST_TIMEOUT_FLAG: assert property (o_rsp_valid && o_rsp.timeout |-> !o_rsp.ok)
      else $error("timeout reported as success");
   cover property (o_rsp_valid && o_rsp.timeout);
   cover property (o_rsp_valid && o_rsp.ok);
   cover property ($rose(o_pins.ce_hv));
endmodule
bind fes_flash_host fes_host_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
   .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_pins(o_pins), .o_dq(o_dq),
   .o_dq_oe(o_dq_oe), .i_dq(i_dq));
`default_nettype wire

// ### fes_flash_model.sv
// Behavioural model of the parallel flash device
`timescale 1ns/10ps
`default_nettype none
module fes_flash_model #(
   parameter int BUSY_CYC = 60,
   // Identification codes, values arbitrary
   parameter logic [7:0] MAKER_CODE = 8'h6b,
   parameter logic [7:0] VARIANT_CODE = 8'h5a
) (
   input wire logic i_clk,
   input wire fes_pkg::fes_pins_type i_pins,
   input wire logic [7:0] i_wdata,
   input wire logic i_stuck,
   output logic [7:0] o_dq
);
   import fes_pkg::*;
   logic [7:0] mem [int];
   fes_pins_type prev = '1;
   logic [7:0] loaded = 8'hff;
   logic [7:0] last = 8'h00;
   logic [7:0] d;
   logic [18:0] a;
   logic id_cmd = 1'b0;
   logic locked = 1'b0;
   logic tog = 1'b0;
   int busy = 0;
   int step = 0;
   wire logic rd = !i_pins.ce_n && !i_pins.oe_n && i_pins.we_n;
   function automatic logic [7:0] arr(input logic [18:0] x);
      return mem.exists(x) ? mem[x] : 8'hff;
   endfunction
   always @*
      if (!rd) o_dq = ~last;
      else if (busy > 0) o_dq = {~loaded[7], tog, loaded[5:0]};
      else if (id_cmd || i_pins.id_voltage_address_pin_hv)
         o_dq = i_pins.addr[1] ? {7'h00, locked} : i_pins.addr[0] ? VARIANT_CODE : MAKER_CODE;
      else o_dq = arr(i_pins.addr);
   always @(negedge i_clk)
   begin
      a = prev.addr;
      d = i_wdata;
      if (busy > 0 && !i_stuck) busy = busy - 1;
      if (i_pins.oe_hv && i_pins.id_voltage_address_pin_hv && !i_pins.we_n)
         locked = i_pins.ce_hv ? 1'b0 : (!i_pins.ce_n | locked);
      if (rd && prev.oe_n && busy > 0) tog = ~tog;
      if (rd) last = o_dq;
      // strobe rise, sampled, dropped while busy
      if (!prev.we_n && i_pins.we_n && !prev.ce_n && prev.oe_n && !prev.oe_hv && busy == 0)
      begin
         if (step == 0 && d != 8'haa) id_cmd = 1'b0;
         case (step)
            0, 3: step = (a == 19'h05555 && d == 8'haa) ? step + 1 : 0;
            1, 4: step = (a == 19'h02aaa && d == 8'h55) ? step + 1 : 0;
            2:
            begin
               id_cmd = (a == 19'h05555 && d == 8'h90);
               step = (a != 19'h05555) ? 0 : (d == 8'ha0) ? 7 : (d == 8'h80) ? 3 : 0;
            end
            5:
            begin
               step = 0;
               if (a == 19'h05555 && d == 8'h10)
               begin
                  mem.delete();
                  loaded = 8'hff;
                  busy = BUSY_CYC;
               end
            end
            7:
            begin
               mem[a] = arr(a) & d;
               loaded = d;
               busy = BUSY_CYC;
               step = 0;
            end
            default: step = 0;
         endcase
      end
      prev = i_pins;
   end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the flash command controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import fes_pkg::*;
   // Identification codes, values arbitrary
   localparam logic [7:0] MAKER = 8'h6b;
   localparam logic [7:0] VARIANT = 8'h5a;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_req_valid = 1'b0;
   logic stuck = 1'b0;
   logic o_req_ready;
   logic o_rsp_valid;
   logic o_dq_oe;
   logic [7:0] o_dq;
   logic [7:0] i_dq;
   fes_req_type i_req = '0;
   fes_rsp_type o_rsp;
   fes_rsp_type rsp;
   fes_pins_type o_pins;
   int num_errors = 0;
   int total_checks = 0;
   always #4 i_clk = ~i_clk;
   fes_flash_host #(.PROG_MAX_CYC(200), .ERASE_MAX_CYC(400), .HV_SETTLE_CYC(4)) u_dut (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid), .i_req(i_req),
      .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_pins(o_pins),
      .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dq(i_dq));
   fes_flash_model #(.MAKER_CODE(MAKER), .VARIANT_CODE(VARIANT)) u_flash (
      .i_clk(i_clk), .i_pins(o_pins), .i_wdata(o_dq), .i_stuck(stuck), .o_dq(i_dq));
   task automatic give_verdict();
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_op(input fes_op_type op, input logic [18:0] a, input logic [7:0] d);
      int n;
      @(posedge i_clk);
      i_req <= '{op: op, addr: a, data: d};
      i_req_valid <= 1'b1;
      do @(negedge i_clk); while (o_req_ready !== 1'b1);
      @(posedge i_clk);
      i_req_valid <= 1'b0;
      n = 0;
      while (o_rsp_valid !== 1'b1 && n < 3000)
      begin
         @(negedge i_clk);
         n++;
      end
      rsp = o_rsp;
      chk8({7'h00, n >= 3000}, 8'h00);
   endtask
   task automatic t_program();
      do_op(fes_op_program, 19'h12345, 8'h5a);
      chk8({6'h00, rsp.ok, rsp.timeout}, 8'h02);
      chk8(rsp.data, 8'h5a);
      do_op(fes_op_read, 19'h12345, 8'h00);
      chk8(rsp.data, 8'h5a);
   endtask
   task automatic t_erase();
      do_op(fes_op_chip_erase, 19'h05555, 8'h10);
      chk8({6'h00, rsp.ok, rsp.timeout}, 8'h02);
      chk8(rsp.data, 8'hff);
      do_op(fes_op_read, 19'h12345, 8'h00);
      chk8(rsp.data, 8'hff);
   endtask
   task automatic t_ident();
      do_op(fes_op_id_cmd, 19'h05555, 8'h90);
      do_op(fes_op_read, 19'h00000, 8'h00);
      chk8(rsp.data, MAKER);
      do_op(fes_op_read, 19'h00001, 8'h00);
      chk8(rsp.data, VARIANT);
      do_op(fes_op_read, 19'h3c002, 8'h00);
      chk8(rsp.data, 8'h00);
      do_op(fes_op_reset, 19'h05555, 8'hf0);
      do_op(fes_op_read, 19'h00000, 8'h00);
      chk8(rsp.data, 8'hff);
   endtask
   task automatic t_protect();
      do_op(fes_op_lock, 19'h00000, 8'h00);
      do_op(fes_op_id_hv, 19'h3c002, 8'h00);
      chk8(rsp.data, 8'h01);
      do_op(fes_op_read, 19'h3c002, 8'h00);
      chk8(rsp.data, 8'hff);
      do_op(fes_op_unlock, 19'h00000, 8'h00);
      do_op(fes_op_id_hv, 19'h3c002, 8'h00);
      chk8(rsp.data, 8'h00);
      do_op(fes_op_id_hv, 19'h00001, 8'h00);
      chk8(rsp.data, VARIANT);
   endtask
   task automatic t_timeout();
      stuck <= 1'b1;
      do_op(fes_op_chip_erase, 19'h05555, 8'h10);
      chk8({6'h00, rsp.ok, rsp.timeout}, 8'h01);
   endtask
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_program();
      t_erase();
      t_ident();
      t_protect();
      t_timeout();
      give_verdict();
   end
   initial
   begin
      #100000;
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
endmodule
`default_nettype wire
